// file: hw/ssg_defines.svh
`ifndef SSG_DEFINES_SVH
`define SSG_DEFINES_SVH

`define SSG_A_CTRL    8'h00
`define SSG_A_LVS     8'h04
`define SSG_A_GATE    8'h08
`define SSG_A_FINE    8'h0C
`define SSG_A_LIM     8'h10
`define SSG_A_THMAX   8'h14
`define SSG_A_INF     8'h18
`define SSG_A_THMIN   8'h1C
`define SSG_A_SLOPE   8'h20
`define SSG_A_STAT    8'h24

`define SSG_R_CTRL    32'h0000_0004
`define SSG_R_LVS     32'h0000_0400
`define SSG_R_GATE    32'h0000_0000
`define SSG_R_FINE    32'h0000_0000
`define SSG_R_LIM     32'h0000_0000
`define SSG_R_THMAX   32'h0000_2EE0
`define SSG_R_INF     32'h0000_2EE0
`define SSG_R_THMIN   32'h0000_0000
`define SSG_R_SLOPE   32'h0001_0000

`define SSG_C_MODE    0
`define SSG_C_TMODE   2
`define SSG_C_GEN     3
`define SSG_C_GRDIS   4
`define SSG_C_FINE    5
`define SSG_C_LIMEN   6
`define SSG_C_HREN    7
`define SSG_C_PAUSE   8
`define SSG_C_CMB     9
`define SSG_C_BSRC    10
`define SSG_L_FTH     0
`define SSG_L_HYS     5
`define SSG_L_RTH     9
`define SSG_L_BDLY    12
`define SSG_L_CDLY    14
`define SSG_L_LOW     16
`define SSG_G_LVL     0
`define SSG_G_HYS     2
`define SSG_G_FHYS    5
`define SSG_M_ATK     0
`define SSG_M_HLD     4
`define SSG_M_RLS     7
`define SSG_M_MAX     11
`define SSG_M_DEV     15
`define SSG_M_DHR     22

`define SSG_RTH_STEP_MV 16'd350
`define SSG_HR_MARGIN   16'd2500
`define SSG_DRAIN       4'd8
`define SSG_LOW_BASE    5'd20

`endif

// file: hw/ssg_pkg.sv
package ssg_pkg;
    typedef enum logic [1:0] {
        SSG_DUAL  = 2'b00,
        SSG_RSVD  = 2'b01,
        SSG_HVONL = 2'b10,
        SSG_LOWPW = 2'b11
    } ssg_mode_t;
    typedef enum {
        SSG_HV,
        SSG_HOLD,
        SSG_DRAINING,
        SSG_BAT,
        SSG_RETURN
    } ssg_state_t;
endpackage : ssg_pkg

// file: hw/ssg_top.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ssg_defines.svh"

// Behaviour
// - Compare raw sample magnitude with level threshold; high level uses high rail.
// - Level below threshold longer than hysteresis time moves bridge to battery.
// - Remaining high samples drain out before the bypass pin is released high.
// - Bypass pin is open drain; a device needing high rail pulls it low.
// - On rising level, pull bypass low after one delay, bridge after another.
// - Reset selects relative threshold mode, relative field 3'b010 (0.7 V).
// - Mode 11 uses the low fixed threshold; mode 00 the 5-bit fixed one when relative threshold mode is off.
// - Mode 00 switches the bridge dynamically between both rails.
// - Mode 01 behaves as mode 10; mode 10 is high rail only.
// - Mode 11 drops to battery only at near-idle signal levels.
// - In dual mode, high rail below battery plus 2.5 V stays on high rail.
// - Gate enabled: long quiet input powers stage down; ramp unless disabled.
// - Loud input re-powers the stage at the first loud sample, automatically.
// - Fine gating uses 24-bit level and fine hysteresis instead of coarse.
// - Combined limiter and brownout attenuation is capped at device maximum.
// - Brownout has priority; limiter and alignment pause until it releases.
// - Combine mode bit selects sum or maximum of the two attenuations.
// - Limiter reduces gain above threshold with attack, hold, release rates.
// - Attack stops once limiter attenuation reaches limiter maximum field.
// - Threshold is max above inflection, falls by slope times drop, floored.
// - Headroom mode sets limit to supply minus signed percentage headroom.
// - Limiter updates freeze during brownout until it releases; only a cleared limiter enable bit overrides this, clearing the attenuation.
module ssg_top (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [7:0]        s_axi_awaddr_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    output logic [1:0]             s_axi_bresp_o,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    input  wire logic [7:0]        s_axi_araddr_i,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    input  wire logic              sample_valid_i,
    input  wire logic [23:0]       sample_i,
    input  wire logic [15:0]       hv_rail_mv_i,
    input  wire logic [15:0]       bat_rail_mv_i,
    input  wire logic              brownout_active_i,
    input  wire logic [6:0]        brownout_atten_i,
    input  wire logic              bypass_enable_pin_i,
    output logic                   bypass_enable_pin_o,
    output logic                   bypass_enable_pin_oe_n_o,
    output logic                   rail_hv_sel_o,
    output logic                   gate_power_down_o,
    output logic                   gate_ramp_en_o,
    output logic                   align_pause_o,
    output logic [6:0]             total_atten_o,
    output ssg_pkg::ssg_mode_t     supply_mode_o,
    output logic                   battery_rail_source_o
);
    import ssg_pkg::*;

    logic [31:0] ctrl_q, lvs_q, gate_q, fine_q, lim_q;
    logic [31:0] thmax_q, inf_q, thmin_q, slope_q;
    logic        bvalid_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q, bresp_q;
    logic        wr_go, wr_hit;

    // Address and data are taken together, one write at a time.
    assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o  = wr_go;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        wr_hit = 1'b1;
        unique case (s_axi_awaddr_i)
            `SSG_A_CTRL, `SSG_A_LVS, `SSG_A_GATE, `SSG_A_FINE,
            `SSG_A_LIM, `SSG_A_THMAX, `SSG_A_INF, `SSG_A_THMIN,
            `SSG_A_SLOPE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_q  <= `SSG_R_CTRL;
            lvs_q   <= `SSG_R_LVS;
            gate_q  <= `SSG_R_GATE;
            fine_q  <= `SSG_R_FINE;
            lim_q   <= `SSG_R_LIM;
            thmax_q <= `SSG_R_THMAX;
            inf_q   <= `SSG_R_INF;
            thmin_q <= `SSG_R_THMIN;
            slope_q <= `SSG_R_SLOPE;
        end else if (wr_go) begin
            unique case (s_axi_awaddr_i)
                `SSG_A_CTRL:  ctrl_q  <= merge(ctrl_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_LVS:   lvs_q   <= merge(lvs_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_GATE:  gate_q  <= merge(gate_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_FINE:  fine_q  <= merge(fine_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_LIM:   lim_q   <= merge(lim_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_THMAX: thmax_q <= merge(thmax_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_INF:   inf_q   <= merge(inf_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_THMIN: thmin_q <= merge(thmin_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                `SSG_A_SLOPE: slope_q <= merge(slope_q, s_axi_wdata_i,
                                               s_axi_wstrb_i);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'b00;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? 2'b00 : 2'b10;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // Field views.
    ssg_mode_t   mode;
    logic        tmode, g_en, fine_en, limiter_enable_bit, hr_en, cmb;
    logic [4:0]  fth, dhr;
    logic [3:0]  hys, atk, rls, lmax;
    logic [2:0]  rth, hld, ghys;
    logic [1:0]  bdly, cdly, lowth, glvl;
    logic [15:0] fhys;
    logic [6:0]  devmax;
    assign mode    = ssg_mode_t'(ctrl_q[`SSG_C_MODE +: 2]);
    assign tmode   = ctrl_q[`SSG_C_TMODE];
    assign g_en    = ctrl_q[`SSG_C_GEN];
    assign fine_en = ctrl_q[`SSG_C_FINE];
    assign limiter_enable_bit  = ctrl_q[`SSG_C_LIMEN];
    assign hr_en   = ctrl_q[`SSG_C_HREN];
    assign cmb     = ctrl_q[`SSG_C_CMB];
    assign fth     = lvs_q[`SSG_L_FTH +: 5];
    assign hys     = lvs_q[`SSG_L_HYS +: 4];
    assign rth     = lvs_q[`SSG_L_RTH +: 3];
    assign bdly    = lvs_q[`SSG_L_BDLY +: 2];
    assign cdly    = lvs_q[`SSG_L_CDLY +: 2];
    assign lowth   = lvs_q[`SSG_L_LOW +: 2];
    assign glvl    = gate_q[`SSG_G_LVL +: 2];
    assign ghys    = gate_q[`SSG_G_HYS +: 3];
    assign fhys    = gate_q[`SSG_G_FHYS +: 16];
    assign atk     = lim_q[`SSG_M_ATK +: 4];
    assign hld     = lim_q[`SSG_M_HLD +: 3];
    assign rls     = lim_q[`SSG_M_RLS +: 4];
    assign lmax    = lim_q[`SSG_M_MAX +: 4];
    assign devmax  = lim_q[`SSG_M_DEV +: 7];
    assign dhr     = lim_q[`SSG_M_DHR +: 5];
    assign supply_mode_o         = mode;
    assign battery_rail_source_o = ctrl_q[`SSG_C_BSRC];

    // Sample magnitude, taken before any attenuation is applied.
    logic [23:0] mag;
    logic [4:0]  lz;
    logic [31:0] peak_mv;
    assign mag = sample_i[23] ? 24'(~sample_i + 24'h1) : sample_i;
    always_comb begin
        lz = 5'd24;
        for (int i = 0; i < 24; i++) begin
            if (mag[i]) begin
                lz = 5'(23 - i);
            end
        end
    end
    // Full scale maps to the high rail voltage.
    assign peak_mv = (32'(mag[23:8]) * 32'(hv_rail_mv_i)) >> 15;

    // Level detector: fixed thresholds are in 6 dB steps below full scale.
    logic [15:0] rel_mv;
    logic        above;
    assign rel_mv = bat_rail_mv_i - 16'(rth * `SSG_RTH_STEP_MV);
    always_comb begin
        if (mode == SSG_LOWPW) begin
            above = lz < (`SSG_LOW_BASE + 5'(lowth));
        end else if (tmode) begin
            above = peak_mv > 32'(rel_mv);
        end else begin
            above = lz < fth;
        end
    end

    logic       hr_low;
    assign hr_low = 17'(hv_rail_mv_i) <
                    17'(bat_rail_mv_i) + 17'(`SSG_HR_MARGIN);

    ssg_state_t  st_q;
    logic [19:0] lcnt_q;
    logic [3:0]  dcnt_q;
    logic [2:0]  rcnt_q;
    logic        rail_q, byp_low_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_q      <= SSG_HV;
            lcnt_q    <= 20'h0_0000;
            dcnt_q    <= 4'h0;
            rcnt_q    <= 3'h0;
            rail_q    <= 1'b1;
            byp_low_q <= 1'b1;
        end else if (sample_valid_i) begin
            if (mode == SSG_HVONL || mode == SSG_RSVD ||
                (mode == SSG_DUAL && hr_low)) begin
                st_q      <= SSG_HV;
                rail_q    <= 1'b1;
                byp_low_q <= 1'b1;
                lcnt_q    <= 20'h0_0000;
            end else begin
                unique case (st_q)
                    SSG_HV: begin
                        lcnt_q <= 20'h0_0000;
                        if (!above) st_q <= SSG_HOLD;
                    end
                    SSG_HOLD: begin
                        if (above) begin
                            st_q <= SSG_HV;
                        end else if (lcnt_q >= (20'h1_0 << hys)) begin
                            st_q   <= SSG_DRAINING;
                            dcnt_q <= 4'h0;
                        end else begin
                            lcnt_q <= lcnt_q + 20'h1;
                        end
                    end
                    SSG_DRAINING: begin
                        if (above) begin
                            st_q <= SSG_HV;
                        end else if (dcnt_q == `SSG_DRAIN) begin
                            st_q      <= SSG_BAT;
                            rail_q    <= 1'b0;
                            byp_low_q <= 1'b0;
                        end else begin
                            dcnt_q <= dcnt_q + 4'h1;
                        end
                    end
                    SSG_BAT: begin
                        if (above) begin
                            st_q   <= SSG_RETURN;
                            rcnt_q <= 3'h0;
                        end
                    end
                    SSG_RETURN: begin
                        rcnt_q <= rcnt_q + 3'h1;
                        if (rcnt_q >= 3'(bdly)) byp_low_q <= 1'b1;
                        if (rcnt_q >= 3'(cdly)) rail_q <= 1'b1;
                        if (rcnt_q >= 3'(bdly) && rcnt_q >= 3'(cdly)) begin
                            st_q <= SSG_HV;
                        end
                    end
                endcase
            end
        end
    end

    // Open drain: drive low when high rail is needed, else release.
    assign bypass_enable_pin_o      = 1'b0;
    assign bypass_enable_pin_oe_n_o = ~byp_low_q;
    assign rail_hv_sel_o            = rail_q;

    // Noise gate.
    logic        quiet;
    logic [18:0] glim, gcnt_q;
    logic        gpd_q;
    always_comb begin
        if (fine_en) begin
            quiet = mag < fine_q[23:0];
            glim  = {fhys, 3'b000};
        end else begin
            quiet = lz > (5'd16 - 5'({glvl, 1'b0}));
            glim  = 19'h40 << ghys;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            gcnt_q <= 19'h0_0000;
            gpd_q  <= 1'b0;
        end else if (sample_valid_i) begin
            if (!g_en || !quiet) begin
                gcnt_q <= 19'h0_0000;
                gpd_q  <= 1'b0;
            end else if (gcnt_q >= glim) begin
                gpd_q <= 1'b1;
            end else begin
                gcnt_q <= gcnt_q + 19'h1;
            end
        end
    end
    assign gate_power_down_o = gpd_q;
    assign gate_ramp_en_o = ~ctrl_q[`SSG_C_GRDIS];

    // Limiter threshold in millivolts.
    logic [31:0] lim_th;
    logic [47:0] drop_prod, hr_prod;
    logic [31:0] drop_mv, tr_th;
    logic [4:0]  dhr_abs;
    assign drop_prod = 48'(slope_q) * 48'(inf_q - 32'(hv_rail_mv_i));
    assign drop_mv   = drop_prod[47:16];
    assign dhr_abs   = dhr[4] ? 5'(~dhr + 5'h1) : dhr;
    // Percentage as multiply by 1311 / 2^17.
    assign hr_prod   = 48'(hv_rail_mv_i) * 48'(dhr_abs) * 48'd1311;
    always_comb begin
        if (32'(hv_rail_mv_i) >= inf_q) begin
            tr_th = thmax_q;
        end else if (drop_mv >= thmax_q || thmax_q - drop_mv < thmin_q) begin
            tr_th = thmin_q;
        end else begin
            tr_th = thmax_q - drop_mv;
        end
        if (hr_en) begin
            lim_th = dhr[4] ? 32'(hv_rail_mv_i) + 32'(hr_prod[47:17])
                            : 32'(hv_rail_mv_i) - 32'(hr_prod[47:17]);
        end else begin
            lim_th = tr_th;
        end
    end

    // Limiter envelope, one step per rate period in samples.
    logic [6:0]  latt_q;
    logic [15:0] rcnt2_q;
    logic [7:0]  hcnt_q;
    logic        pause, over;
    assign pause = brownout_active_i;
    assign over  = peak_mv > lim_th;
    assign align_pause_o = brownout_active_i;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            latt_q  <= 7'h00;
            rcnt2_q <= 16'h0000;
            hcnt_q  <= 8'h00;
        end else if (!limiter_enable_bit) begin
            latt_q  <= 7'h00;
            rcnt2_q <= 16'h0000;
            hcnt_q  <= 8'h00;
        end else if (sample_valid_i && !pause) begin
            rcnt2_q <= rcnt2_q + 16'h1;
            if (over) begin
                hcnt_q <= 8'h00;
                if (rcnt2_q >= (16'h1 << atk)) begin
                    rcnt2_q <= 16'h0000;
                    if (latt_q < 7'(lmax)) latt_q <= latt_q + 7'h1;
                end
            end else if (hcnt_q < (8'h1 << hld)) begin
                hcnt_q <= hcnt_q + 8'h1;
            end else if (rcnt2_q >= (16'h1 << rls)) begin
                rcnt2_q <= 16'h0000;
                if (latt_q != 7'h00) latt_q <= latt_q - 7'h1;
            end
        end
    end

    logic [7:0] comb;
    logic [6:0] tot_q;
    always_comb begin
        if (cmb) begin
            comb = {1'b0, (latt_q > brownout_atten_i) ? latt_q
                                                       : brownout_atten_i};
        end else begin
            comb = 8'(latt_q) + 8'(brownout_atten_i);
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tot_q <= 7'h00;
        end else begin
            tot_q <= (comb > 8'(devmax)) ? devmax : comb[6:0];
        end
    end
    assign total_atten_o = tot_q;

    // Read side.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'b00;
        end else if (s_axi_arvalid_i && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= 2'b00;
            unique case (s_axi_araddr_i)
                `SSG_A_CTRL:  rdata_q <= ctrl_q;
                `SSG_A_LVS:   rdata_q <= lvs_q;
                `SSG_A_GATE:  rdata_q <= gate_q;
                `SSG_A_FINE:  rdata_q <= fine_q;
                `SSG_A_LIM:   rdata_q <= lim_q;
                `SSG_A_THMAX: rdata_q <= thmax_q;
                `SSG_A_INF:   rdata_q <= inf_q;
                `SSG_A_THMIN: rdata_q <= thmin_q;
                `SSG_A_SLOPE: rdata_q <= slope_q;
                `SSG_A_STAT:  rdata_q <= {6'h00, tot_q, latt_q,
                                          bypass_enable_pin_i, hr_low,
                                          gpd_q, byp_low_q, rail_q,
                                          3'(st_q), above, 3'h0};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'b10;
                end
            endcase
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule : ssg_top
`default_nettype wire

// file: tb/ssg_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module ssg_top_props (
    input wire logic              clk_sys_i,
    input wire logic              reset_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_wvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic              s_axi_wready_o,
    input wire logic              s_axi_bvalid_o,
    input wire logic              s_axi_bready_i,
    input wire logic [1:0]        s_axi_bresp_o,
    input wire logic              sample_valid_i,
    input wire logic [15:0]       hv_rail_mv_i,
    input wire logic [15:0]       bat_rail_mv_i,
    input wire logic              brownout_active_i,
    input wire logic              align_pause_o,
    input wire logic              bypass_enable_pin_o,
    input wire logic              bypass_enable_pin_oe_n_o,
    input wire logic              rail_hv_sel_o,
    input wire logic              gate_power_down_o,
    input wire ssg_pkg::ssg_mode_t supply_mode_o
);
    import ssg_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o && s_axi_wready_o;
    endsequence
    sequence s_hv_low;
        rail_hv_sel_o && sample_valid_i && supply_mode_o == SSG_DUAL &&
        ({1'b0, hv_rail_mv_i} < {1'b0, bat_rail_mv_i} + 17'h009C4);
    endsequence
    a_rail_on_sample: assert property (
        !sample_valid_i |=> $stable(rail_hv_sel_o)) else $error("rail moved");
    a_gate_on_sample: assert property (
        !sample_valid_i |=> $stable(gate_power_down_o)) else $error("gate moved");
    a_byp_on_sample: assert property (
        !sample_valid_i |=> $stable(bypass_enable_pin_oe_n_o))
        else $error("bypass moved");
    a_pause_follows: assert property (
        align_pause_o == brownout_active_i) else $error("pause differs");
    a_pin_drain: assert property (
        bypass_enable_pin_o == 1'b0) else $error("pin driven high");
    a_hv_only: assert property (
        supply_mode_o == SSG_HVONL && sample_valid_i |=> rail_hv_sel_o)
        else $error("left high rail");
    a_release_bat: assert property (
        $rose(bypass_enable_pin_oe_n_o) |-> !rail_hv_sel_o)
        else $error("bypass released on high rail");
    a_low_hv_stay: assert property (
        s_hv_low |=> rail_hv_sel_o) else $error("switched on low rail gap");
    a_wr_answer: assert property (
        s_wr_taken |=> s_axi_bvalid_o) else $error("no write answer");
    a_b_hold: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
        $stable(s_axi_bresp_o)) else $error("write answer dropped");
endmodule : ssg_top_props
`default_nettype wire

// file: tb/ssg_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssg_peer_model (
    input  wire logic peer_need_i,
    input  wire logic dut_oe_n_i,
    input  wire logic dut_drive_i,
    output logic      pin_level_o
);
    // Pulled up unless a device that needs the high rail pulls it low.
    assign pin_level_o = (dut_oe_n_i | dut_drive_i) & ~peer_need_i;
endmodule : ssg_peer_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssg_defines.svh"
module tb;
    import ssg_pkg::*;
    localparam logic [23:0] LOUD = 24'h40_0000;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic        sv = 1'b0, bo = 1'b0, peer = 1'b0;
    logic        awr, wrd, bv, arr, rv, pin, pdrv, oen, rail, gpd;
    logic [1:0]  br, rr;
    logic [7:0]  aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rd, r;
    logic [23:0] smp = 24'h0;
    logic [15:0] hv = 16'h2EE0, bat = 16'h0ED8;
    logic [6:0]  boa = 7'h00, tot;
    logic [33:0] q[$];
    int          fail_count = 0, n_compared = 0;
    integer      seed = 32'h8A71;
    always #5 clk_sys_i = ~clk_sys_i;
    ssg_top dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(aw),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ar), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .sample_valid_i(sv),
        .sample_i(smp), .hv_rail_mv_i(hv), .bat_rail_mv_i(bat),
        .brownout_active_i(bo), .brownout_atten_i(boa),
        .bypass_enable_pin_i(pin), .bypass_enable_pin_o(pdrv),
        .bypass_enable_pin_oe_n_o(oen), .rail_hv_sel_o(rail),
        .gate_power_down_o(gpd), .gate_ramp_en_o(), .align_pause_o(),
        .total_atten_o(tot), .supply_mode_o(), .battery_rail_source_o());
    ssg_peer_model peer_m (.peer_need_i(peer), .dut_oe_n_i(oen),
        .dut_drive_i(pdrv), .pin_level_o(pin));
    task automatic chk(input logic [33:0] e, input logic [33:0] a);
        n_compared++;
        if (a !== e) begin
            fail_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic tout;
        fail_count++;
        end_sim();
    endtask : tout
    always @(posedge clk_sys_i) if (rv && rre) chk(q.pop_front(), {rr, rd});
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] e);
        int i = 0;
        @(posedge clk_sys_i);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do @(posedge clk_sys_i); while (!(awr && wrd) && i++ < 50);
        awv <= 1'b0;
        wv <= 1'b0;
        while (!bv && i++ < 100) @(posedge clk_sys_i);
        bre <= 1'b0;
        if (i >= 100) tout();
        chk({32'h0, e}, {32'h0, br});
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        int i = 0;
        q.push_back(e);
        @(posedge clk_sys_i);
        ar <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk_sys_i); while (!arr && i++ < 50);
        arv <= 1'b0;
        while (!rv && i++ < 100) @(posedge clk_sys_i);
        rre <= 1'b0;
        if (i >= 100) tout();
    endtask : axr
    // Random sign and low bits exercise the magnitude compare.
    task automatic snd(input int n, input logic [23:0] v);
        repeat (n) begin
            @(posedge clk_sys_i);
            r = $random(seed);
            sv <= 1'b1;
            smp <= r[0] ? -(v ^ r[2:1]) : v ^ r[2:1];
            bo <= r[3];
            boa <= r[10:4];
            peer <= r[11];
            @(posedge clk_sys_i);
            sv <= 1'b0;
        end
        @(negedge clk_sys_i);
    endtask : snd
    task automatic pc(input logic [1:0] e);
        chk({32'h0, e}, {32'h0, rail, oen});
    endtask : pc
    task automatic gc(input logic e);
        chk({33'h0, e}, {33'h0, gpd});
    endtask : gc
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        pc(2'b10);
        axr(`SSG_A_CTRL, {2'b00, 32'h0000_0004});
        axr(`SSG_A_LVS, {2'b00, 32'h0000_0400});
        axr(8'h3C, {2'b10, 32'h0});
        axw(8'h3C, 32'h0, 2'b10);
        $display("registers done");
        axw(`SSG_A_CTRL, 32'h0, 2'b00);
        axw(`SSG_A_LVS, 32'h0000_D004, 2'b00);
        snd(3, LOUD);
        pc(2'b10);
        snd(16, 24'h1);
        pc(2'b10);
        snd(4, 24'h1);
        pc(2'b10);
        snd(10, 24'h1);
        pc(2'b01);
        snd(1, LOUD);
        pc(2'b01);
        snd(2, LOUD);
        pc(2'b00);
        snd(2, LOUD);
        pc(2'b10);
        hv <= 16'h0FA0;
        snd(30, 24'h1);
        pc(2'b10);
        hv <= 16'h2EE0;
        $display("dual rail done");
        axw(`SSG_A_CTRL, 32'h2, 2'b00);
        snd(30, 24'h1);
        chk({33'h0, 1'b1}, {33'h0, rail});
        axw(`SSG_A_CTRL, 32'h3, 2'b00);
        snd(30, 24'h800);
        chk({33'h0, 1'b1}, {33'h0, rail});
        snd(30, 24'h1);
        chk({33'h0, 1'b0}, {33'h0, rail});
        $display("modes done");
        axw(`SSG_A_CTRL, 32'hA, 2'b00);
        snd(60, 24'h1);
        gc(1'b0);
        snd(10, 24'h1);
        gc(1'b1);
        snd(1, LOUD);
        gc(1'b0);
        axw(`SSG_A_FINE, 32'h1000, 2'b00);
        axw(`SSG_A_GATE, 32'h40, 2'b00);
        axw(`SSG_A_CTRL, 32'h2A, 2'b00);
        snd(20, 24'h800);
        gc(1'b1);
        $display("gate done");
        axw(`SSG_A_LIM, 32'h0008_0000, 2'b00);
        snd(2, LOUD);
        chk({27'h0, boa > 7'h10 ? 7'h10 : boa}, {27'h0, tot});
        end_sim();
    end
endmodule : tb
bind ssg_top ssg_top_props props (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o), .sample_valid_i(sample_valid_i),
    .hv_rail_mv_i(hv_rail_mv_i), .bat_rail_mv_i(bat_rail_mv_i),
    .brownout_active_i(brownout_active_i), .align_pause_o(align_pause_o),
    .bypass_enable_pin_o(bypass_enable_pin_o),
    .bypass_enable_pin_oe_n_o(bypass_enable_pin_oe_n_o),
    .rail_hv_sel_o(rail_hv_sel_o), .gate_power_down_o(gate_power_down_o),
    .supply_mode_o(supply_mode_o));
`default_nettype wire
